// ### bwf_pkg.sv
// Package for the byte-wide input buffer: register map, field layout,
// reset values, byte-lane states and the sample carrier.
// Assumes the register port carries 8-bit data and 5-bit addresses.
`default_nettype none

package bwf_pkg;

  // ****************************************************************
  // Register port geometry.
  // ****************************************************************
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;

  // ****************************************************************
  // Register offsets.
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CTRL_ZERO_ADDR  = 5'h00;
  localparam logic [ADDR_W-1:0] BUF_MODE_ADDR   = 5'h01;
  localparam logic [ADDR_W-1:0] BUF_OFFSET_ADDR = 5'h03;
  localparam logic [ADDR_W-1:0] ALARM_STAT_ADDR = 5'h07;
  localparam logic [ADDR_W-1:0] ALARM_MASK_ADDR = 5'h11;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int unsigned RESYNC_ENA_BIT = 5;
  localparam int unsigned BUF_ENA_BIT    = 2;
  localparam int unsigned MSYNC_ENA_BIT  = 1;
  localparam int unsigned INTERP_LSB     = 6;
  localparam int unsigned INTERP_W       = 2;
  localparam int unsigned LIVE_LSB       = 4;
  localparam int unsigned ALARM_N        = 3;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [DATA_W-1:0] CTRL_ZERO_RST  = 8'h20;
  localparam logic [DATA_W-1:0] BUF_MODE_RST   = 8'h46;
  localparam logic [DATA_W-1:0] BUF_OFFSET_RST = 8'h04;
  localparam logic [DATA_W-1:0] ALARM_MASK_RST = 8'h00;

  // ****************************************************************
  // Buffer geometry and pointer constants.
  // ****************************************************************
  localparam int unsigned PTR_W      = 3;
  localparam int unsigned DEPTH      = 8;
  localparam int unsigned WORD_W     = 16;
  localparam logic [PTR_W-1:0] WPTR_HOME = 3'h0;
  localparam logic [PTR_W-1:0] PTR_ONE   = 3'h1;
  localparam logic [PTR_W-1:0] PTR_TWO   = 3'h2;
  localparam logic [PTR_W-1:0] PTR_SIX   = 3'h6;
  localparam logic [PTR_W-1:0] PTR_SEVEN = 3'h7;

  // Interpolation codes for factors 1 and 2; divider terminal counts for factors 1, 2 and 4.
  localparam logic [1:0] INTERP_X1 = 2'h0;
  localparam logic [1:0] INTERP_X2 = 2'h1;
  localparam logic [1:0] DIV_LAST1 = 2'h0;
  localparam logic [1:0] DIV_LAST2 = 2'h1;
  localparam logic [1:0] DIV_LAST4 = 2'h3;

  // Byte lane inside one sample, Gray coded along the usual path.
  typedef enum logic [1:0] {
    BWF_I_HI = 2'b00,
    BWF_I_LO = 2'b01,
    BWF_Q_HI = 2'b11,
    BWF_Q_LO = 2'b10
  } bwf_lane_t;

  // One complete sample, I and Q, bit 0 the least significant.
  typedef struct packed {
    logic [WORD_W-1:0] i_word;
    logic [WORD_W-1:0] q_word;
  } bwf_sample_t;

  // Alarm bits: two apart, one apart, collision.
  typedef struct packed {
    logic two_apart;
    logic one_apart;
    logic collision;
  } bwf_alarm_t;

endpackage : bwf_pkg

`default_nettype wire

// ### bwf_input_buffer.sv
// Byte-wide input buffer: DDR byte capture, sample assembly, an 8-deep
// elastic store, pointer resync by the frame marker, alarms and bypass.
// Assumes the data clock and frame marker are sampled as plain inputs on
// i_ref_clk, which stands for the converter clock and runs well faster.
//
// Contract
// - Eight bits per data clock edge, both edges; four bytes form one sample.
// - In each 16-bit word bit 0 is LSB and bit 15 is MSB.
// - Frame marker is sampled only on rising data clock edges.
// - Elastic store holds 8 samples of two 16-bit channels.
// - Samples written at write pointer, read at read pointer, both advance.
// - Read rate is converter clock divided by the interpolation factor.
// - Pointer reset: write pointer to 0, read pointer to offset, default 4.
// - With resync and multi-sync enabled in buffer mode a marker rise resets both pointers.
// - Pointers wrap automatically after visiting all addresses.
// - Marker resets repeat while resync bit 5 is set; software may clear it.
// - Overrun or underrun duplicates or skips samples; only alarms report it.
// - Alarms for pointers within two, within one, and equal.
// - Alarms readable in the status register and routable to the alarm pin.
// - Buffer enable clear selects bypass regardless of the other two bits.
// - In bypass, data passes straight through; pointers do not matter.
//
// The placing of the registers and strobed register access are this design's own decisions.
`default_nettype none

module bwf_input_buffer (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_input_data_clock,
  input  wire logic [7:0]                 i_data_byte,
  input  wire logic                       i_frame_marker,
  input  wire logic [bwf_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic [bwf_pkg::DATA_W-1:0] i_reg_wdata,
  input  wire logic                       i_reg_wr,
  input  wire logic                       i_reg_rd,
  output logic      [bwf_pkg::DATA_W-1:0] o_reg_rdata,
  output var bwf_pkg::bwf_sample_t        o_sample,
  output logic                            o_sample_valid,
  output logic                            o_alarm_output_pin
);
  import bwf_pkg::*;

  // ****************************************************************
  // Register file.
  // ****************************************************************
  logic [DATA_W-1:0] ctrl_zero_ff;
  logic [DATA_W-1:0] buf_mode_ff;
  logic [DATA_W-1:0] buf_offset_ff;
  logic [DATA_W-1:0] alarm_mask_ff;
  bwf_alarm_t        alarm_sticky_ff;
  bwf_alarm_t        nxt_alarm_sticky;
  logic [DATA_W-1:0] nxt_rdata;

  // ****************************************************************
  // Data path state.
  // ****************************************************************
  logic              dclk_prev_ff;
  logic              frame_prev_ff;
  bwf_lane_t         lane_ff;
  bwf_lane_t         nxt_lane;
  logic [7:0]        i_hi_ff;
  logic [7:0]        i_lo_ff;
  logic [7:0]        q_hi_ff;
  bwf_sample_t       mem_ff [DEPTH];
  bwf_sample_t       bypass_ff;
  logic [PTR_W-1:0]  wptr_ff;
  logic [PTR_W-1:0]  rptr_ff;
  logic [1:0]        div_ff;
  bwf_alarm_t        live_ff;

  // Control fields decoded from the registers.
  wire logic             resync_ena = ctrl_zero_ff[RESYNC_ENA_BIT];
  wire logic             buf_ena    = buf_mode_ff[BUF_ENA_BIT];
  wire logic             msync_ena  = buf_mode_ff[MSYNC_ENA_BIT];
  wire logic [1:0]       interp_sel =
    buf_mode_ff[INTERP_LSB +: INTERP_W];
  wire logic [PTR_W-1:0] rptr_home  = buf_offset_ff[PTR_W-1:0];

  // ****************************************************************
  // Edge detection on the data clock level.
  // ****************************************************************
  // Both edges carry a byte; only the rising one looks at the marker.
  wire logic dclk_rise = i_input_data_clock & ~dclk_prev_ff;
  wire logic dclk_fall = ~i_input_data_clock & dclk_prev_ff;
  wire logic byte_take = dclk_rise | dclk_fall;
  // A marker rise counts only on a rising data clock edge.
  wire logic frame_rise = dclk_rise & i_frame_marker
                        & ~frame_prev_ff;

  // The pointer resync needs the resync and multi-sync bits in buffer mode.
  wire logic ptr_reset = frame_rise & resync_ena & msync_ena
                       & buf_ena;

  // ****************************************************************
  // Byte lane sequencing.
  // ****************************************************************
  // The marker edge pins the current byte as the I high byte.
  always_comb begin
    nxt_lane = lane_ff;
    if (byte_take) begin
      if (frame_rise) begin
        nxt_lane = BWF_I_LO;
      end else begin
        case (lane_ff)
          BWF_I_HI: nxt_lane = BWF_I_LO;
          BWF_I_LO: nxt_lane = BWF_Q_HI;
          BWF_Q_HI: nxt_lane = BWF_Q_LO;
          BWF_Q_LO: nxt_lane = BWF_I_HI;
          default:  nxt_lane = BWF_I_HI;
        endcase
      end
    end
  end

  wire bwf_lane_t cur_lane = frame_rise ? BWF_I_HI : lane_ff;
  wire logic      sample_done = byte_take & (cur_lane == BWF_Q_LO);
  // High byte sits in bits 15:8, so bit 0 of each word is its LSB.
  wire bwf_sample_t new_sample = '{i_word: {i_hi_ff, i_lo_ff},
                                   q_word: {q_hi_ff, i_data_byte}};

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dclk_prev_ff  <= 1'b0;
      frame_prev_ff <= 1'b0;
      lane_ff       <= BWF_I_HI;
    end else begin
      dclk_prev_ff <= i_input_data_clock;
      if (dclk_rise) begin
        frame_prev_ff <= i_frame_marker;
      end
      lane_ff <= nxt_lane;
    end
  end

  // Partial bytes wait here until the last byte of the sample lands.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      i_hi_ff <= 8'h00;
      i_lo_ff <= 8'h00;
      q_hi_ff <= 8'h00;
    end else if (byte_take) begin
      if (cur_lane == BWF_I_HI) i_hi_ff <= i_data_byte;
      if (cur_lane == BWF_I_LO) i_lo_ff <= i_data_byte;
      if (cur_lane == BWF_Q_HI) q_hi_ff <= i_data_byte;
    end
  end

  // ****************************************************************
  // Elastic store and write pointer.
  // ****************************************************************
  // One storage word per address; only the addressed entry loads.
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        mem_ff[g] <= '0;
      end else if (sample_done && wptr_ff == PTR_W'(g)) begin
        mem_ff[g] <= new_sample;
      end
    end
  end

  // The pointer wraps on its own through the 3-bit counter.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_ff <= WPTR_HOME;
    end else if (ptr_reset) begin
      wptr_ff <= WPTR_HOME;
    end else if (sample_done) begin
      wptr_ff <= wptr_ff + PTR_ONE;
    end
  end

  // Bypass holds the latest sample for the converter side to take.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bypass_ff <= '0;
    end else if (sample_done) begin
      bypass_ff <= new_sample;
    end
  end

  // ****************************************************************
  // Read rate divider and read pointer.
  // ****************************************************************
  wire logic [1:0] div_last = (interp_sel == INTERP_X1) ? DIV_LAST1 :
                              (interp_sel == INTERP_X2) ? DIV_LAST2 :
                              DIV_LAST4;
  wire logic       rd_tick  = (div_ff >= div_last);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= rd_tick ? 2'h0 : div_ff + 2'h1;
    end
  end

  // Read and write may land on one address; no correction is made.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rptr_ff <= BUF_OFFSET_RST[PTR_W-1:0];
    end else if (ptr_reset) begin
      rptr_ff <= rptr_home;
    end else if (rd_tick && buf_ena) begin
      rptr_ff <= rptr_ff + PTR_ONE;
    end
  end

  // The sample out is taken from the store or straight from capture.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample       <= '0;
      o_sample_valid <= 1'b0;
    end else begin
      o_sample_valid <= rd_tick;
      if (rd_tick) begin
        o_sample <= buf_ena ? mem_ff[rptr_ff] : bypass_ff;
      end
    end
  end

  // ****************************************************************
  // Pointer distance alarms.
  // ****************************************************************
  // Modulo-8 difference gives the gap in either direction.
  wire logic [PTR_W-1:0] gap = wptr_ff - rptr_ff;
  wire bwf_alarm_t live_now = '{
    two_apart: (gap <= PTR_TWO) || (gap >= PTR_SIX),
    one_apart: (gap <= PTR_ONE) || (gap >= PTR_SEVEN),
    collision: (gap == WPTR_HOME)};

  // In bypass the pointers are meaningless, so the alarms stay quiet.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      live_ff <= '0;
    end else begin
      live_ff <= buf_ena ? live_now : '0;
    end
  end

  // ****************************************************************
  // Register port.
  // ****************************************************************
  wire logic wr_ctrl = i_reg_wr && (i_reg_addr == CTRL_ZERO_ADDR);
  wire logic wr_mode = i_reg_wr && (i_reg_addr == BUF_MODE_ADDR);
  wire logic wr_offs = i_reg_wr && (i_reg_addr == BUF_OFFSET_ADDR);
  wire logic wr_stat = i_reg_wr && (i_reg_addr == ALARM_STAT_ADDR);
  wire logic wr_mask = i_reg_wr && (i_reg_addr == ALARM_MASK_ADDR);

  // Writing 0 clears a sticky bit, but a fresh alarm wins the same cycle.
  always_comb begin
    nxt_alarm_sticky = alarm_sticky_ff;
    if (wr_stat) begin
      nxt_alarm_sticky = alarm_sticky_ff & i_reg_wdata[ALARM_N-1:0];
    end
    nxt_alarm_sticky = nxt_alarm_sticky | live_ff;
  end

  // Unmapped addresses read as zero.
  always_comb begin
    nxt_rdata = '0;
    if (i_reg_addr == CTRL_ZERO_ADDR) begin
      nxt_rdata = ctrl_zero_ff;
    end else if (i_reg_addr == BUF_MODE_ADDR) begin
      nxt_rdata = buf_mode_ff;
    end else if (i_reg_addr == BUF_OFFSET_ADDR) begin
      nxt_rdata = buf_offset_ff;
    end else if (i_reg_addr == ALARM_STAT_ADDR) begin
      nxt_rdata[ALARM_N-1:0] = alarm_sticky_ff;
      nxt_rdata[LIVE_LSB +: ALARM_N] = live_ff;
    end else if (i_reg_addr == ALARM_MASK_ADDR) begin
      nxt_rdata = alarm_mask_ff;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_zero_ff  <= CTRL_ZERO_RST;
      buf_mode_ff   <= BUF_MODE_RST;
      buf_offset_ff <= BUF_OFFSET_RST;
      alarm_mask_ff <= ALARM_MASK_RST;
    end else begin
      if (wr_ctrl) ctrl_zero_ff <= i_reg_wdata;
      if (wr_mode) buf_mode_ff <= i_reg_wdata;
      if (wr_offs) buf_offset_ff <= i_reg_wdata;
      if (wr_mask) alarm_mask_ff <= i_reg_wdata;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alarm_sticky_ff    <= '0;
      o_reg_rdata        <= '0;
      o_alarm_output_pin <= 1'b0;
    end else begin
      alarm_sticky_ff    <= nxt_alarm_sticky;
      o_reg_rdata        <= i_reg_rd ? nxt_rdata : '0;
      o_alarm_output_pin <=
        |(alarm_sticky_ff & ~alarm_mask_ff[ALARM_N-1:0]);
    end
  end

endmodule : bwf_input_buffer

`default_nettype wire

// ### bwf_src_model.sv
// Behavioural data source for the byte-wide input buffer.
// Assumes i_ref_clk is the converter clock; each data clock phase lasts
// two reference cycles, which is the slowest the block needs.
`default_nettype none
module bwf_src_model (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_go,
  input  wire bwf_pkg::bwf_sample_t i_smp,
  input  wire logic                 i_mark,
  output logic                      o_dclk,
  output logic [7:0]                o_byte,
  output logic                      o_mark,
  output logic                      o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import bwf_pkg::*;
  // ****************************************************************
  // Frame sender.
  // ****************************************************************
  // Lines start quiet so the first marker is seen as a rise. One sample
  // is four clock edges; the clock then stands still low. Each phase is
  // a whole number of reference cycles, so the data clock keeps a fixed
  // phase to the converter clock, which bypass depends on.
  // Exactly one sample per request: the bench sets the write rate.
  initial begin
    o_dclk = 1'b0;
    o_byte = 8'h00;
    o_mark = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_ref_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        o_mark <= i_mark;
        for (int k = 0; k < 4; k++) begin
          o_dclk <= ~o_dclk;
          o_byte <= i_smp[31-8*k -: 8];
          repeat (2) @(posedge i_ref_clk);
          o_mark <= 1'b0;
        end
        // Released bus shows a changed value, never the last byte.
        o_byte <= ~o_byte;
        o_busy <= 1'b0;
      end
    end
  end
endmodule : bwf_src_model
`default_nettype wire

// ### bwf_input_buffer_sva.sv
// Port checker for the byte-wide input buffer.
// Assumes configuration reaches the block only over its register port.
`default_nettype none
module bwf_checker (
  input wire logic                       i_ref_clk,
  input wire logic                       i_rst_n,
  input wire logic [bwf_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [bwf_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic                       i_reg_wr,
  input wire logic                       i_reg_rd,
  input wire logic [bwf_pkg::DATA_W-1:0] o_reg_rdata,
  input wire bwf_pkg::bwf_sample_t       o_sample,
  input wire logic                       o_sample_valid,
  input wire logic                       o_alarm_output_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import bwf_pkg::*;
  // ****************************************************************
  // Shadow configuration.
  // ****************************************************************
  logic [7:0] mode_ff;
  logic [2:0] off_ff;
  logic [2:0] mask_ff;
  logic       resync_ff;
  logic [3:0] age_ff;
  logic [3:0] nxt_age;
  logic       wr_mode;
  logic       mapped;
  // Age 0 means mode never written: the reset divider is not trusted.
  assign wr_mode = i_reg_wr && i_reg_addr == BUF_MODE_ADDR;
  assign nxt_age = wr_mode ? 4'h1 :
                   (age_ff != 4'h0 && age_ff != 4'hF) ? age_ff + 4'h1 : age_ff;
  assign mapped = i_reg_addr inside {CTRL_ZERO_ADDR, BUF_MODE_ADDR,
                  BUF_OFFSET_ADDR, ALARM_STAT_ADDR, ALARM_MASK_ADDR};
  // Mirrors of the writable fields, updated on the write strobe.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_ff   <= BUF_MODE_RST;
      off_ff    <= BUF_OFFSET_RST[2:0];
      mask_ff   <= ALARM_MASK_RST[2:0];
      resync_ff <= CTRL_ZERO_RST[RESYNC_ENA_BIT];
      age_ff    <= 4'h0;
    end else begin
      age_ff <= nxt_age;
      if (wr_mode) mode_ff <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == BUF_OFFSET_ADDR)
        off_ff <= i_reg_wdata[2:0];
      if (i_reg_wr && i_reg_addr == ALARM_MASK_ADDR)
        mask_ff <= i_reg_wdata[2:0];
      if (i_reg_wr && i_reg_addr == CTRL_ZERO_ADDR)
        resync_ff <= i_reg_wdata[RESYNC_ENA_BIT];
    end
  end
  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_rdata_idle_zero: assert property (
    !i_reg_rd |=> o_reg_rdata == 8'h00) else $error("read data not idle");
  a_unmapped_read: assert property (
    i_reg_rd && !mapped |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_offset_readback: assert property (
    i_reg_rd && i_reg_addr == BUF_OFFSET_ADDR |=>
    o_reg_rdata[2:0] == $past(off_ff)) else $error("offset readback wrong");
  a_resync_readback: assert property (
    i_reg_rd && i_reg_addr == CTRL_ZERO_ADDR |=>
    o_reg_rdata[5] == $past(resync_ff)) else $error("resync bit wrong");
  a_sample_hold: assert property (
    $changed(o_sample) |-> o_sample_valid)
    else $error("sample moved without valid");
  a_rate_one: assert property (
    age_ff == 4'hF && mode_ff[7:6] == 2'b00 |-> o_sample_valid)
    else $error("valid missing at factor one");
  a_rate_two: assert property (
    o_sample_valid && age_ff == 4'hF && mode_ff[7:6] == 2'b01 |=>
    !o_sample_valid ##1 o_sample_valid) else $error("factor two spacing");
  a_rate_four: assert property (
    o_sample_valid && age_ff == 4'hF && mode_ff[7] |=>
    !o_sample_valid [*3] ##1 o_sample_valid)
    else $error("factor four spacing");
  a_bypass_no_live: assert property (
    i_reg_rd && i_reg_addr == ALARM_STAT_ADDR && !mode_ff[BUF_ENA_BIT] &&
    age_ff == 4'hF |=> o_reg_rdata[6:4] == 3'h0)
    else $error("live alarm in bypass");
  a_pin_masked: assert property (
    mask_ff == 3'h7 && $past(mask_ff, 4) == 3'h7 |-> !o_alarm_output_pin)
    else $error("masked alarm on pin");
endmodule : bwf_checker
bind bwf_input_buffer bwf_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_sample(o_sample),
  .o_sample_valid(o_sample_valid), .o_alarm_output_pin(o_alarm_output_pin));
`default_nettype wire

// ### byte_wide_input_fifo_bench.sv
// Self-checking bench for the byte-wide input buffer.
// Assumes the source model drives the data side and tasks drive registers.
`default_nettype none
module byte_wide_input_fifo_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bwf_pkg::*;
  logic ref_clk, rst_n, dclk, mark, go, smp_mark, busy;
  logic reg_wr, reg_rd, valid, pin;
  logic [7:0] dbyte, reg_wdata, reg_rdata;
  logic [4:0] reg_addr;
  bwf_sample_t smp, sample;
  int bad_count, checks, cyc;
  // ****************************************************************
  // Instances, clock and watchdog.
  // ****************************************************************
  bwf_input_buffer dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
    .i_input_data_clock(dclk), .i_data_byte(dbyte), .i_frame_marker(mark),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_sample(sample),
    .o_sample_valid(valid), .o_alarm_output_pin(pin));
  bwf_src_model u_src (.i_ref_clk(ref_clk), .i_go(go), .i_smp(smp),
    .i_mark(smp_mark), .o_dclk(dclk), .o_byte(dbyte), .o_mark(mark),
    .o_busy(busy));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // A hang is cut short far beyond the few hundred cycles the run needs.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // Mode changes wait so a running pulse spacing check is not cut.
  task automatic set_mode(input logic [7:0] m);
    repeat (6) @(posedge ref_clk);
    reg_write(BUF_MODE_ADDR, m);
    repeat (16) @(posedge ref_clk);
  endtask : set_mode
  task automatic wait_valid(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (valid !== 1'b1 && n < 20);
  endtask : wait_valid
  task automatic send(input bwf_sample_t s, input logic m);
    int n;
    @(posedge ref_clk);
    smp <= s;
    smp_mark <= m;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    n = 0;
    #1 while (busy === 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask : send
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_regs;
    logic [7:0] d;
    reg_read(CTRL_ZERO_ADDR, d);
    chk(32'(d[5]), 32'h1);
    reg_read(BUF_OFFSET_ADDR, d);
    chk(32'(d), 32'h04);
    reg_write(BUF_OFFSET_ADDR, 8'h02);
    reg_read(BUF_OFFSET_ADDR, d);
    chk(32'(d), 32'h02);
    reg_write(BUF_OFFSET_ADDR, 8'h04);
    reg_write(5'h1F, 8'hFF);
    reg_read(5'h1F, d);
    chk(32'(d), 32'h00);
  endtask : t_regs
  task automatic t_interp;
    int n;
    for (int c = 0; c < 4; c++) begin
      set_mode({2'(c), 6'h06});
      wait_valid(n);
      wait_valid(n);
      chk(32'(n), (c == 0) ? 32'h1 : (c == 1) ? 32'h2 : 32'h4);
    end
  endtask : t_interp
  task automatic t_buffer_data;
    logic hit;
    hit = 1'b0;
    set_mode(8'h86);
    send(32'hC3A5_5A3C, 1'b1);
    repeat (80) begin
      @(posedge ref_clk);
      #1 if (valid === 1'b1 && sample === 32'hC3A5_5A3C) hit = 1'b1;
    end
    chk(32'(hit), 32'h1);
  endtask : t_buffer_data
  task automatic t_alarms;
    logic [7:0] d;
    repeat (40) @(posedge ref_clk);
    reg_read(ALARM_STAT_ADDR, d);
    chk(32'(d[2:0]), 32'h7);
    chk(32'(pin), 32'h1);
    reg_write(ALARM_MASK_ADDR, 8'h07);
    repeat (5) @(posedge ref_clk);
    chk(32'(pin), 32'h0);
    reg_write(ALARM_MASK_ADDR, 8'h00);
    set_mode(8'h82);
    reg_write(ALARM_STAT_ADDR, 8'h06);
    reg_read(ALARM_STAT_ADDR, d);
    chk(32'(d), 32'h06);
    reg_write(ALARM_STAT_ADDR, 8'h00);
    repeat (4) @(posedge ref_clk);
    reg_read(ALARM_STAT_ADDR, d);
    chk(32'(d), 32'h00);
    chk(32'(pin), 32'h0);
  endtask : t_alarms
  task automatic t_bypass;
    int n;
    send(32'h8001_1234, 1'b1);
    wait_valid(n);
    chk(sample, 32'h8001_1234);
    send(32'h00FF_7E01, 1'b0);
    wait_valid(n);
    chk(sample, 32'h00FF_7E01);
  endtask : t_bypass
  task automatic tally_and_finish;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence: reset, then each scenario in turn.
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    smp = '0;
    smp_mark = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_interp();
    t_buffer_data();
    t_alarms();
    t_bypass();
    tally_and_finish();
  end
endmodule : byte_wide_input_fifo_bench
`default_nettype wire
